// ---- design/pfps_recovery.sv ----
module pfps_recovery #(
	parameter int unsigned SHORT_CYC = 40000,
	parameter int unsigned LONG_CYC = 400000,
	parameter int unsigned CW = 20
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic nrst_in,
	// control
	input wire logic clr_in,
	input wire logic fault_in,
	// status
	output logic hold_out,
	output logic long_out
);
	import pfps_pkg::*;

	// ----------------------------------------------------------------
	// recovery sequencer for one fault class
	// ----------------------------------------------------------------
	pfps_rec_state_t st_r;
	pfps_rec_state_t st_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		unique case (st_r)
			REC_IDLE: begin
				cnt_nxt = '0;
				if (fault_in) begin
					st_nxt = REC_SHORT;
				end
			end
			// the short interval runs from fault onset
			REC_SHORT: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == CW'(SHORT_CYC - 1)) begin
					cnt_nxt = '0;
					if (fault_in) begin
						st_nxt = REC_LONG_WAIT;
					end else begin
						st_nxt = REC_IDLE;
					end
				end
			end
			REC_LONG_WAIT: begin
				cnt_nxt = '0;
				if (!fault_in) begin
					st_nxt = REC_LONG_CNT;
				end
			end
			// a returning fault restarts the long wait
			REC_LONG_CNT: begin
				cnt_nxt = cnt_r + 1'b1;
				if (fault_in) begin
					st_nxt = REC_LONG_WAIT;
					cnt_nxt = '0;
				end else if (cnt_r == CW'(LONG_CYC - 1)) begin
					st_nxt = REC_IDLE;
					cnt_nxt = '0;
				end
			end
		endcase
		if (clr_in) begin
			st_nxt = REC_IDLE;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r <= REC_IDLE;
			cnt_r <= '0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign hold_out = (st_r != REC_IDLE);
	assign long_out = (st_r == REC_LONG_WAIT) || (st_r == REC_LONG_CNT);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	short_expiry_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		(st_r == REC_SHORT && cnt_r == CW'(SHORT_CYC - 1) && fault_in &&
		!clr_in) |=> (st_r == REC_LONG_WAIT && cnt_r == '0))
		else $error("fault present at short expiry did not go long");

	long_restart_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		(st_r == REC_LONG_CNT && fault_in && !clr_in) |=>
		(st_r == REC_LONG_WAIT && cnt_r == '0))
		else $error("returning fault did not restart long recovery");

	early_release_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		($fell(hold_out) && !$past(clr_in)) |->
		($past(st_r) == REC_SHORT && !$past(fault_in)) ||
		($past(st_r) == REC_LONG_CNT && !$past(fault_in)))
		else $error("hold released from a wrong state");

endmodule : pfps_recovery

// ---- design/pfps_sequencer.sv ----
// Notes on behaviour
// - data overvoltage opens every switch fast, asserts fault output
// - data fault gone at short expiry: switches close, fault releases later
// - data fault still present at expiry: wait clear, then long interval
// - either channel overvoltage opens every switch and asserts fault
// - channel fault gone at short expiry: reclose, then release fault
// - channel fault persisting: hold open until clear plus long interval
// - ground short drives gate low, sets flag, opens switches, asserts
// - ground short cleared after interval: switches close, gate goes high
// - ground short persisting: gate low until clear plus long interval
// - over-temperature opens every switch like any other fault
// - three reporting choices: all, all but backvoltage, all but overvolt
// - low supply is a protection condition that opens the pass path
// - mask strap: low reports all, open hides backvolt, high hides ov
// - masking changes only the report, never switch behaviour
// - under low supply only the ground-short gate driver stays alive
module pfps_sequencer #(
	parameter int unsigned CW = pfps_pkg::TIMER_W,
	parameter int unsigned DATA_REC_CYC = pfps_pkg::DATA_OV_RECOVER_CYC,
	parameter int unsigned DATA_LONG_CYC = pfps_pkg::DATA_OV_LONG_RECOVER_CYC,
	parameter int unsigned CHAN_REC_CYC = pfps_pkg::CHAN_OV_RECOVER_CYC,
	parameter int unsigned CHAN_LONG_CYC = pfps_pkg::CHAN_OV_LONG_RECOVER_CYC,
	parameter int unsigned GND_REC_CYC = pfps_pkg::GND_SHORT_RECOVER_CYC,
	parameter int unsigned GND_LONG_CYC =
		pfps_pkg::GND_SHORT_LONG_RECOVER_CYC,
	parameter int unsigned TEMP_REC_CYC = pfps_pkg::OVERTEMP_RECOVER_CYC,
	parameter int unsigned BV_REC_CYC = pfps_pkg::BACKVOLT_RECOVER_CYC,
	parameter int unsigned REL_CYC = pfps_pkg::FAULT_RELEASE_CYC
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic nrst_in,
	// comparator flags and strap
	input wire pfps_pkg::pfps_flags_t flags_in,
	input wire pfps_pkg::pfps_mask_t fault_mask_select_in,
	// pass switches and external gate
	output pfps_pkg::pfps_sw_t pass_sw_out,
	output logic ground_short_gate_out,
	// status
	output logic ground_short_flag_out,
	output logic fault_n_out
);
	import pfps_pkg::*;

	// local copies so delay bounds stay plain constants
	localparam int DRESP = DATA_OV_RESPONSE_CYC;
	localparam int CRESP = CHAN_OV_RESPONSE_CYC;
	localparam int GRESP = GND_SHORT_RESPONSE_CYC;
	localparam int FASRT = FAULT_ASSERT_CYC;
	localparam int unsigned REC_SHORT_C [NUM_CLS] = '{DATA_REC_CYC,
		CHAN_REC_CYC, GND_REC_CYC, TEMP_REC_CYC, BV_REC_CYC};
	localparam int unsigned REC_LONG_C [NUM_CLS] = '{DATA_LONG_CYC,
		CHAN_LONG_CYC, GND_LONG_CYC, TEMP_REC_CYC, BV_REC_CYC};

	// report filter for one strap setting
	function automatic logic [NUM_CLS-1:0] report_filter(input pfps_mask_t m);
		logic [NUM_CLS-1:0] f;
		f = CLS_ALL;
		unique case (m)
			MASK_REPORT_ALL: f = CLS_ALL;
			MASK_HIDE_BACKVOLT: f = CLS_HIDE_BV;
			MASK_HIDE_OVERVOLT: f = CLS_HIDE_OV;
			// undefined strap code reports everything, the safe side
			default: f = CLS_ALL;
		endcase
		return f;
	endfunction : report_filter

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [NUM_FLAGS-1:0] meta_r;
	logic [NUM_FLAGS-1:0] sync_r;
	pfps_flags_t flg;

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= flags_in;
			sync_r <= meta_r;
		end
	end

	assign flg = sync_r;

	// ----------------------------------------------------------------
	// per-class recovery sequencers
	// ----------------------------------------------------------------
	logic [NUM_CLS-1:0] cls_fault;
	logic [NUM_CLS-1:0] hold;
	logic [NUM_CLS-1:0] hold_long;
	logic [NUM_CLS-1:0] cls_clr;

	assign cls_fault[CLS_DATA] = flg.data_ov;
	assign cls_fault[CLS_CHAN] = flg.chan_a_ov | flg.chan_b_ov;
	assign cls_fault[CLS_GND] = flg.gnd_short;
	assign cls_fault[CLS_TEMP] = flg.overtemp;
	assign cls_fault[CLS_BV] = flg.backvolt;

	// low supply resets every sequencer except the ground-short one
	always_comb begin
		cls_clr = {NUM_CLS{flg.undervolt}};
		cls_clr[CLS_GND] = 1'b0;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CLS; gi++) begin : g_rec
			pfps_recovery #(
				.SHORT_CYC(REC_SHORT_C[gi]),
				.LONG_CYC(REC_LONG_C[gi]),
				.CW(CW)
			) u_rec (
				.core_clk_in(core_clk_in),
				.nrst_in(nrst_in),
				.clr_in(cls_clr[gi]),
				.fault_in(cls_fault[gi]),
				.hold_out(hold[gi]),
				.long_out(hold_long[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// pass switches and ground-short gate
	// ----------------------------------------------------------------
	pfps_sw_t sw_r;
	pfps_sw_t sw_nxt;
	logic gate_r;
	logic gate_nxt;
	logic gflag_r;
	logic gflag_nxt;
	logic any_hold;

	// every class must be idle before anything recloses
	assign any_hold = |hold;

	always_comb begin
		sw_nxt = SW_ALL_CLOSED;
		if (any_hold || cls_fault != CLS_NONE || flg.undervolt) begin
			sw_nxt = SW_ALL_OPEN;
		end
		// gate driver keeps working in undervoltage
		gflag_nxt = cls_fault[CLS_GND] | hold[CLS_GND];
		gate_nxt = !gflag_nxt;
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sw_r <= SW_ALL_OPEN;
			gate_r <= 1'b0;
			gflag_r <= 1'b0;
		end else begin
			sw_r <= sw_nxt;
			gate_r <= gate_nxt;
			gflag_r <= gflag_nxt;
		end
	end

	// ----------------------------------------------------------------
	// fault output and release delay
	// ----------------------------------------------------------------
	pfps_mask_t mask_r;
	logic [NUM_CLS-1:0] reported;
	logic rep_any;
	logic fault_n_r;
	logic fault_n_nxt;
	logic [REL_W-1:0] rel_r;
	logic [REL_W-1:0] rel_nxt;

	// the mask only filters the report; switches ignore it
	assign reported = (hold | cls_fault) & report_filter(mask_r);
	assign rep_any = |reported;

	always_comb begin
		fault_n_nxt = fault_n_r;
		rel_nxt = '0;
		if (flg.undervolt) begin
			fault_n_nxt = 1'b1;
		end else if (rep_any) begin
			fault_n_nxt = 1'b0;
		end else if (!fault_n_r && sw_r == SW_ALL_CLOSED) begin
			// release only once the switches have reclosed
			rel_nxt = rel_r + 1'b1;
			if (rel_r == REL_W'(REL_CYC - 1)) begin
				fault_n_nxt = 1'b1;
				rel_nxt = '0;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mask_r <= MASK_REPORT_ALL;
			fault_n_r <= 1'b1;
			rel_r <= '0;
		end else begin
			mask_r <= fault_mask_select_in;
			fault_n_r <= fault_n_nxt;
			rel_r <= rel_nxt;
		end
	end

	assign pass_sw_out = sw_r;
	assign ground_short_gate_out = gate_r;
	assign ground_short_flag_out = gflag_r;
	assign fault_n_out = fault_n_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	data_ov_open_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		$rose(flags_in.data_ov) |-> ##[1:DRESP] (sw_r == SW_ALL_OPEN))
		else $error("switches not open after data overvoltage");

	data_ov_report_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		($rose(flags_in.data_ov) && mask_r == MASK_REPORT_ALL &&
		!flg.undervolt && !flags_in.undervolt)
		|-> ##[1:FASRT] !fault_n_r)
		else $error("fault output not asserted for data overvoltage");

	chan_ov_open_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		($rose(flags_in.chan_a_ov) || $rose(flags_in.chan_b_ov)) |->
		##[1:CRESP] (sw_r == SW_ALL_OPEN))
		else $error("switches not open after channel overvoltage");

	gnd_gate_low_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		$rose(flags_in.gnd_short) |-> ##[1:GRESP]
		(!gate_r && gflag_r && sw_r == SW_ALL_OPEN))
		else $error("ground short not acted on in time");

	gnd_gate_high_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		$fell(hold[CLS_GND]) && !cls_fault[CLS_GND] |=> gate_r)
		else $error("gate not driven high after ground short recovery");

	uvlo_off_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		flg.undervolt |=> (sw_r == SW_ALL_OPEN && fault_n_r))
		else $error("undervoltage did not disable the pass path");

	close_clean_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		(sw_r != SW_ALL_OPEN) |-> $past(!any_hold && !flg.undervolt))
		else $error("switches closed while a fault was still held");

	mask_report_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		$fell(fault_n_r) |-> $past(rep_any))
		else $error("fault output asserted for a masked fault");

	release_delay_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		($rose(fault_n_r) && !$past(flg.undervolt)) |->
		$past(sw_r == SW_ALL_CLOSED, REL_CYC))
		else $error("fault output released before the release delay");

	masked_open_a: assert property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		(hold[CLS_DATA] && mask_r == MASK_HIDE_OVERVOLT) |=>
		(sw_r == SW_ALL_OPEN))
		else $error("masked data fault left switches closed");

	cover_short_rec_c: cover property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		$fell(hold[CLS_DATA]) && !hold_long[CLS_DATA]);

	cover_long_rec_c: cover property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		hold_long[CLS_CHAN] ##1 !hold[CLS_CHAN]);

	cover_gnd_c: cover property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		!gate_r ##1 gate_r);

	cover_release_c: cover property (@(posedge core_clk_in)
		disable iff (!nrst_in)
		!fault_n_r ##1 fault_n_r);

endmodule : pfps_sequencer

// ---- include/pfps_pkg.sv ----
package pfps_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;

	// response limits are longest times: they round down
	localparam int DATA_OV_RESPONSE_TIME_NS = 200;
	localparam int CHAN_OV_RESPONSE_TIME_NS = 200;
	localparam int GND_SHORT_RESPONSE_TIME_NS = 200;
	localparam int FAULT_ASSERT_DELAY_NS = 200;
	localparam int DATA_OV_RESPONSE_CYC = DATA_OV_RESPONSE_TIME_NS /
		CLK_PERIOD_NS;
	localparam int CHAN_OV_RESPONSE_CYC = CHAN_OV_RESPONSE_TIME_NS /
		CLK_PERIOD_NS;
	localparam int GND_SHORT_RESPONSE_CYC = GND_SHORT_RESPONSE_TIME_NS /
		CLK_PERIOD_NS;
	localparam int FAULT_ASSERT_CYC = FAULT_ASSERT_DELAY_NS / CLK_PERIOD_NS;

	// recovery and release intervals are least times: they round up
	localparam int DATA_OV_RECOVER_TIME_NS = 1000000;
	localparam int DATA_OV_LONG_RECOVER_TIME_NS = 10000000;
	localparam int CHAN_OV_RECOVER_TIME_NS = 1000000;
	localparam int CHAN_OV_LONG_RECOVER_TIME_NS = 10000000;
	localparam int GND_SHORT_RECOVER_TIME_NS = 1000000;
	localparam int GND_SHORT_LONG_RECOVER_TIME_NS = 10000000;
	localparam int OVERTEMP_RECOVER_TIME_NS = 1000000;
	localparam int BACKVOLT_RECOVER_TIME_NS = 1000000;
	localparam int FAULT_RELEASE_DELAY_NS = 2000;

	localparam int DATA_OV_RECOVER_CYC = (DATA_OV_RECOVER_TIME_NS +
		CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_OV_LONG_RECOVER_CYC = (DATA_OV_LONG_RECOVER_TIME_NS +
		CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CHAN_OV_RECOVER_CYC = (CHAN_OV_RECOVER_TIME_NS +
		CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CHAN_OV_LONG_RECOVER_CYC = (CHAN_OV_LONG_RECOVER_TIME_NS +
		CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GND_SHORT_RECOVER_CYC = (GND_SHORT_RECOVER_TIME_NS +
		CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GND_SHORT_LONG_RECOVER_CYC =
		(GND_SHORT_LONG_RECOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OVERTEMP_RECOVER_CYC = (OVERTEMP_RECOVER_TIME_NS +
		CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BACKVOLT_RECOVER_CYC = (BACKVOLT_RECOVER_TIME_NS +
		CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAULT_RELEASE_CYC = (FAULT_RELEASE_DELAY_NS +
		CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int TIMER_W = 20;
	localparam int REL_W = 8;

	// ----------------------------------------------------------------
	// fault classes and carriers
	// ----------------------------------------------------------------
	localparam int CLS_DATA = 0;
	localparam int CLS_CHAN = 1;
	localparam int CLS_GND = 2;
	localparam int CLS_TEMP = 3;
	localparam int CLS_BV = 4;
	localparam int NUM_CLS = 5;
	localparam int NUM_FLAGS = 7;

	typedef struct packed {
		logic undervolt;
		logic backvolt;
		logic overtemp;
		logic gnd_short;
		logic chan_b_ov;
		logic chan_a_ov;
		logic data_ov;
	} pfps_flags_t;

	typedef struct packed {
		logic vconn;
		logic connector_chan_b;
		logic connector_chan_a;
		logic data_n;
		logic data_p;
	} pfps_sw_t;

	localparam pfps_sw_t SW_ALL_OPEN = 5'h00;
	localparam pfps_sw_t SW_ALL_CLOSED = 5'h1f;
	localparam logic [NUM_CLS-1:0] CLS_NONE = 5'h00;
	localparam logic [NUM_CLS-1:0] CLS_ALL = 5'h1f;
	localparam logic [NUM_CLS-1:0] CLS_HIDE_BV = 5'h0f;
	localparam logic [NUM_CLS-1:0] CLS_HIDE_OV = 5'h1c;

	// three-level strap, coded: low, open, high
	typedef enum logic [1:0] {
		MASK_REPORT_ALL = 2'h0,
		MASK_HIDE_BACKVOLT = 2'h1,
		MASK_HIDE_OVERVOLT = 2'h2
	} pfps_mask_t;

	typedef enum logic [1:0] {
		REC_IDLE = 2'h0,
		REC_SHORT = 2'h1,
		REC_LONG_WAIT = 2'h2,
		REC_LONG_CNT = 2'h3
	} pfps_rec_state_t;

endpackage : pfps_pkg

// ---- sim/pfps_port_model.sv ----
module pfps_port_model
	import pfps_pkg::*;
(
	// ----------------------------------------------------------------
	// clock and reset
	// ----------------------------------------------------------------
	input wire logic core_clk_in,
	input wire logic nrst_in,
	// line conditions commanded by the bench
	input wire pfps_pkg::pfps_flags_t cond_in,
	// comparator flags towards the sequencer
	output pfps_pkg::pfps_flags_t flags_out,
	// host fault monitor
	input wire logic fault_n_in,
	output int fault_events_out
);
	timeunit 1ns;
	timeprecision 100ps;

	logic fault_n_q;

	// comparators follow the line levels; the sequencer syncs them
	assign flags_out = cond_in;

	// host counts each falling edge of the active-low fault line
	always @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fault_n_q <= 1'b1;
			fault_events_out <= 0;
		end else begin
			fault_n_q <= fault_n_in;
			if (fault_n_q && !fault_n_in) begin
				fault_events_out <= fault_events_out + 1;
			end
		end
	end
endmodule : pfps_port_model

// ---- sim/pfps_sequencer_bench.sv ----
module pfps_sequencer_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import pfps_pkg::*;

	// ----------------------------------------------------------------
	// shortened intervals keep the run small
	// ----------------------------------------------------------------
	localparam int REC = 20;
	localparam int LNG = 50;
	localparam int REL = 10;

	logic core_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	pfps_flags_t cond = '0;
	pfps_flags_t flags;
	pfps_mask_t mask = MASK_REPORT_ALL;
	pfps_sw_t sw;
	logic gate;
	logic gflag;
	logic fault_n;
	int events;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	int i;
	int n;

	always #12.5 core_clk_in = ~core_clk_in;

	pfps_sequencer #(.DATA_REC_CYC(REC), .DATA_LONG_CYC(LNG),
		.CHAN_REC_CYC(REC), .CHAN_LONG_CYC(LNG), .GND_REC_CYC(REC),
		.GND_LONG_CYC(LNG), .TEMP_REC_CYC(REC), .BV_REC_CYC(REC),
		.REL_CYC(REL)) dut (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.flags_in(flags),
		.fault_mask_select_in(mask),
		.pass_sw_out(sw),
		.ground_short_gate_out(gate),
		.ground_short_flag_out(gflag),
		.fault_n_out(fault_n)
	);

	pfps_port_model port (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.cond_in(cond),
		.flags_out(flags),
		.fault_n_in(fault_n),
		.fault_events_out(events)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tick(input int c);
		repeat (c) @(posedge core_clk_in);
		#1;
	endtask : tick

	// bounded wait for a switch pattern
	task automatic wait_sw(input pfps_sw_t want, input int lim,
		output int c);
		c = 0;
		while (sw !== want && c < lim) begin
			tick(1);
			c++;
		end
	endtask : wait_sw

	// flag bits: 0 data, 1 chan a, 2 chan b, 3 gnd, 4 temp, 5 backvolt
	function automatic logic reported(input int idx, input pfps_mask_t m);
		if (m == MASK_HIDE_OVERVOLT && idx <= 2) begin
			return 1'b0;
		end
		if (m == MASK_HIDE_BACKVOLT && idx == 5) begin
			return 1'b0;
		end
		return 1'b1;
	endfunction : reported

	// least cycles from raising the flag that the switches stay open
	function automatic int open_min(input int idx, input int len);
		if (len < REC) begin
			return REC;
		end
		return len + ((idx >= 4) ? REC : LNG) - 2;
	endfunction : open_min

	task automatic run_fault(input int idx, input int len,
		input pfps_mask_t m);
		int c;
		int t;
		int ev0;
		logic rep;
		rep = reported(idx, m);
		mask = m;
		ev0 = events;
		cond[idx] = 1'b1;
		wait_sw(SW_ALL_OPEN, 8, c);
		chk("sw open", SW_ALL_OPEN, sw);
		chk("fault_n set", !rep, fault_n);
		chk("gate low", idx != 3, gate);
		chk("gnd flag", idx == 3, gflag);
		for (t = c; t < open_min(idx, len); t++) begin
			if (t >= len) begin
				cond[idx] = 1'b0;
			end
			tick(1);
		end
		cond[idx] = 1'b0;
		chk("sw held", SW_ALL_OPEN, sw);
		chk("fault_n held", !rep, fault_n);
		wait_sw(SW_ALL_CLOSED, 14, c);
		chk("sw closed", SW_ALL_CLOSED, sw);
		chk("gate high", 1'b1, gate);
		chk("gnd flag off", 1'b0, gflag);
		tick(REL - 2);
		chk("fault_n release", !rep, fault_n);
		tick(5);
		chk("fault_n idle", 1'b1, fault_n);
		chk("host events", 8'(ev0 + rep), 8'(events));
	endtask : run_fault

	// ----------------------------------------------------------------
	// hang guard, about eight times the expected run
	// ----------------------------------------------------------------
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h1119));
		tick(16);
		nrst_in = 1'b1;
		tick(3);
		chk("sw after reset", SW_ALL_CLOSED, sw);
		chk("gate after reset", 1'b1, gate);
		chk("fault_n after reset", 1'b1, fault_n);
		// every class under every strap, length drawn at random
		for (i = 0; i < 24; i++) begin
			run_fault(i % 6, ($urandom % 2) ? 3 : REC + 15,
				pfps_mask_t'(i / 6));
		end
		// every class persisting, strap drawn at random
		for (i = 0; i < 6; i++) begin
			run_fault(i, REC + 5 + ($urandom % 10),
				pfps_mask_t'($urandom % 4));
		end
		// short data fault inside a persisting ground short
		mask = MASK_REPORT_ALL;
		cond.data_ov = 1'b1;
		cond.gnd_short = 1'b1;
		tick(3);
		cond.data_ov = 1'b0;
		tick(REC + 12);
		chk("sw both held", SW_ALL_OPEN, sw);
		cond.gnd_short = 1'b0;
		tick(LNG - 4);
		chk("sw gnd long", SW_ALL_OPEN, sw);
		wait_sw(SW_ALL_CLOSED, 14, n);
		chk("sw both done", SW_ALL_CLOSED, sw);
		tick(REL + 5);
		// channel fault returning during the long count restarts it
		cond.chan_a_ov = 1'b1;
		tick(REC + 15);
		cond.chan_a_ov = 1'b0;
		tick(10);
		cond.chan_b_ov = 1'b1;
		tick(3);
		cond.chan_b_ov = 1'b0;
		tick(LNG - 4);
		chk("sw restart", SW_ALL_OPEN, sw);
		wait_sw(SW_ALL_CLOSED, 14, n);
		chk("sw restart done", SW_ALL_CLOSED, sw);
		tick(REL + 5);
		chk("fault_n restart", 1'b1, fault_n);
		// low supply: path off, report off, ground-short driver alive
		cond.undervolt = 1'b1;
		wait_sw(SW_ALL_OPEN, 8, n);
		chk("uv sw", SW_ALL_OPEN, sw);
		chk("uv fault_n", 1'b1, fault_n);
		cond.gnd_short = 1'b1;
		tick(8);
		chk("uv gate", 1'b0, gate);
		chk("uv fault_n gnd", 1'b1, fault_n);
		cond.gnd_short = 1'b0;
		tick(REC + LNG + 10);
		chk("uv gate back", 1'b1, gate);
		chk("uv sw still", SW_ALL_OPEN, sw);
		cond.undervolt = 1'b0;
		wait_sw(SW_ALL_CLOSED, 6, n);
		chk("uv sw back", SW_ALL_CLOSED, sw);
		// reset in the middle of a ground short
		cond.gnd_short = 1'b1;
		tick(6);
		nrst_in = 1'b0;
		cond.gnd_short = 1'b0;
		tick(1);
		chk("rst sw", SW_ALL_OPEN, sw);
		chk("rst gate", 1'b0, gate);
		chk("rst fault_n", 1'b1, fault_n);
		nrst_in = 1'b1;
		tick(3);
		chk("rst sw back", SW_ALL_CLOSED, sw);
		test_done();
	end
endmodule : pfps_sequencer_bench
